// *** hdl/eeo_pkg.sv ***
// Package of constants and types for the encoder emulation output block.
package eeo_pkg;

  // Position and frame widths.
  localparam int POS_W       = 24;
  localparam int TURN_W      = 12;
  localparam int FRAME_W     = 24;
  localparam int HALF_W      = 12;
  localparam int LINE_W      = 20;
  localparam int CNT_W       = 5;

  // Line count limits before quadrature.
  localparam logic [LINE_W-1:0] RES_LINES_MAX = 20'h01000;
  localparam logic [LINE_W-1:0] ENC_LINES_MIN = 20'h00100;
  localparam logic [LINE_W-1:0] ENC_LINES_MAX = 20'h80000;

  // Interpolation factor exponent limits.
  localparam logic [2:0] INTERP_EXP_MIN = 3'h2;
  localparam logic [2:0] INTERP_EXP_MAX = 3'h7;

  // Function select codes.
  localparam logic [1:0] FUNC_OFF    = 2'h0;
  localparam logic [1:0] FUNC_INCR   = 2'h1;
  localparam logic [1:0] FUNC_SERIAL = 2'h2;
  localparam logic [1:0] FUNC_INTERP = 2'h3;

  // Pole pair settings of the resolver source.
  localparam logic [1:0] POLES_2 = 2'h0;
  localparam logic [1:0] POLES_4 = 2'h1;
  localparam logic [1:0] POLES_6 = 2'h2;

  // Frame reset value and invalid top half.
  localparam logic [FRAME_W-1:0] FRAME_RST = 24'h000000;
  localparam logic [HALF_W-1:0]  INVALID_TOP = 12'hFFF;

  // Serial link timing: word is done after this idle time on the clock.
  localparam int MCLK_MHZ_X10       = 400;
  localparam int SER_SLOW_PERIOD_NS = 5000;
  localparam int SER_FAST_PERIOD_NS = 667;
  localparam int SER_IDLE_NS        = 20000;
  localparam int SER_IDLE_CYC       = (SER_IDLE_NS * MCLK_MHZ_X10) / 10000;
  localparam int IDLE_W             = 10;

  // Quadrature phase states.
  typedef enum logic [3:0] {
    EEO_Q00 = 4'h1,
    EEO_Q10 = 4'h2,
    EEO_Q11 = 4'h4,
    EEO_Q01 = 4'h8
  } eeo_quad_t;

endpackage

// *** hdl/eeo_quad_gen.sv ***
// Quadrature generator that steps A and B one edge per request.
`timescale 1ns/1ps
module eeo_quad_gen (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic reset_n,
  // Step requests.
  input  wire logic step_up,
  input  wire logic step_dn,
  // Quadrature outputs.
  output logic      quad_a,
  output logic      quad_b
);

  eeo_pkg::eeo_quad_t state_r;
  eeo_pkg::eeo_quad_t state_nxt;

  // Gray sequence: up runs 00,10,11,01; down runs the reverse.
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      eeo_pkg::EEO_Q00: state_nxt = step_up ? eeo_pkg::EEO_Q10 : (step_dn ? eeo_pkg::EEO_Q01 : state_r);
      eeo_pkg::EEO_Q10: state_nxt = step_up ? eeo_pkg::EEO_Q11 : (step_dn ? eeo_pkg::EEO_Q00 : state_r);
      eeo_pkg::EEO_Q11: state_nxt = step_up ? eeo_pkg::EEO_Q01 : (step_dn ? eeo_pkg::EEO_Q10 : state_r);
      eeo_pkg::EEO_Q01: state_nxt = step_up ? eeo_pkg::EEO_Q00 : (step_dn ? eeo_pkg::EEO_Q11 : state_r);
      default:          state_nxt = eeo_pkg::EEO_Q00;
    endcase
  end

  // Phase register and registered outputs.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= eeo_pkg::EEO_Q00;
      quad_a  <= 1'b0;
      quad_b  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      quad_a  <= (state_nxt == eeo_pkg::EEO_Q10) || (state_nxt == eeo_pkg::EEO_Q11);
      quad_b  <= (state_nxt == eeo_pkg::EEO_Q11) || (state_nxt == eeo_pkg::EEO_Q01);
    end
  end

  // A and B never change together.
  a_quad_one_edge: assert property (@(posedge mclk) disable iff (!reset_n)
    !($changed(quad_a) && $changed(quad_b))) else $error("A and B changed together");

endmodule

// *** hdl/eeo_pin_sync.sv ***
// Three-stage synchroniser with agreement filter for a pin input.
`timescale 1ns/1ps
module eeo_pin_sync (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic reset_n,
  // Pin and filtered level.
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic agree;

  // The level changes only once stages two and three agree.
  assign agree = (s2_r == s3_r);
  assign level = level_r;
  assign rise  = agree && s2_r && !level_r;
  assign fall  = agree && !s2_r && level_r;

  // Shift chain and filtered level.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
    end else begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (agree) begin
        level_r <= s2_r;
      end
    end
  end

endmodule

// *** hdl/eeo_encoder_emulation_output.sv ***
// Encoder emulation output: quadrature with marker, or serial absolute frame.
`timescale 1ns/1ps
module eeo_encoder_emulation_output (
  // Clock and reset.
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  // Absolute shaft position: turns in the top half, angle in the bottom half.
  input  wire logic [eeo_pkg::POS_W-1:0]  shaft_position,
  input  wire logic                       source_is_encoder,
  input  wire logic [1:0]                 resolver_poles,
  input  wire logic                       commutation_track,
  input  wire logic                       homing_done,
  // Settings.
  input  wire logic [1:0]                 emulation_function_select,
  input  wire logic [eeo_pkg::LINE_W-1:0] line_count,
  input  wire logic [2:0]                 interp_exponent,
  input  wire logic [eeo_pkg::HALF_W-1:0] marker_offset,
  input  wire logic                       multi_turn_select,
  input  wire logic                       serial_code_select,
  input  wire logic                       serial_clock_select,
  input  wire logic                       serial_clock_invert,
  // Interpolation sources.
  input  wire logic                       interp_step_up,
  input  wire logic                       interp_step_dn,
  input  wire logic                       sine_marker,
  // Serial link.
  input  wire logic                       serial_clk,
  output logic                            serial_data,
  // Incremental outputs.
  output logic                            quad_a,
  output logic                            quad_b,
  output logic                            zero_marker
);

  localparam int ACC_W = eeo_pkg::HALF_W + eeo_pkg::LINE_W + 2;
  // One emitted quadrature edge in accumulator units.
  localparam logic [ACC_W-1:0] EDGE_UNIT = ACC_W'(1 << eeo_pkg::HALF_W);

  // Rate information; the link simply follows whatever rate the reader uses.
  localparam int PERIOD_SLOW = eeo_pkg::SER_SLOW_PERIOD_NS;
  localparam int PERIOD_FAST = eeo_pkg::SER_FAST_PERIOD_NS;

  logic [eeo_pkg::HALF_W-1:0]  angle_prev_r;
  logic [ACC_W-1:0]            target_r;
  logic [ACC_W-1:0]            emitted_r;
  logic [ACC_W-1:0]            pos_diff;
  logic [eeo_pkg::LINE_W-1:0]  lines_eff;
  logic [eeo_pkg::HALF_W-1:0]  angle_raw;
  logic [eeo_pkg::HALF_W-1:0]  angle_scaled;
  logic [eeo_pkg::HALF_W-1:0]  delta;
  logic [eeo_pkg::HALF_W-1:0]  rel_angle;
  logic [eeo_pkg::HALF_W-1:0]  rel_prev;
  logic                        wrap_fwd;
  logic                        wrap_back;
  logic                        incr_mode;
  logic                        interp_mode;
  logic                        serial_mode;
  logic                        qstep_up;
  logic                        qstep_dn;
  logic                        qa;
  logic                        qb;
  logic                        marker_armed_r;
  logic                        zero_marker_r;
  logic                        sclk_lvl;
  logic                        sclk_rise;
  logic                        sclk_fall;
  logic                        sclk_lead;
  logic [eeo_pkg::FRAME_W-1:0] frame_raw;
  logic [eeo_pkg::FRAME_W-1:0] frame_word;
  logic [eeo_pkg::FRAME_W-1:0] shift_r;
  logic                        busy_r;
  logic [eeo_pkg::CNT_W-1:0]   bits_r;
  logic [eeo_pkg::IDLE_W-1:0]  idle_r;
  logic                        serial_data_r;
  logic [eeo_pkg::HALF_W-1:0]  top_half;

  // Binary to Gray conversion.
  function automatic logic [eeo_pkg::FRAME_W-1:0] to_gray(input logic [eeo_pkg::FRAME_W-1:0] v);
    to_gray = v ^ (v >> 1);
  endfunction

  // Mode decode.
  assign incr_mode   = (emulation_function_select == eeo_pkg::FUNC_INCR);
  assign interp_mode = (emulation_function_select == eeo_pkg::FUNC_INTERP);
  assign serial_mode = (emulation_function_select == eeo_pkg::FUNC_SERIAL);

  // Line count clamped to the limits of the feedback source.
  assign lines_eff = source_is_encoder ?
    ((line_count < eeo_pkg::ENC_LINES_MIN) ? eeo_pkg::ENC_LINES_MIN :
     (line_count > eeo_pkg::ENC_LINES_MAX) ? eeo_pkg::ENC_LINES_MAX : line_count) :
    ((line_count > eeo_pkg::RES_LINES_MAX) ? eeo_pkg::RES_LINES_MAX :
     (line_count == '0) ? 20'h00001 : line_count);

  // Angle within the turn taken from the absolute position.
  assign angle_raw = shaft_position[eeo_pkg::HALF_W-1:0];
  assign delta     = angle_raw - angle_prev_r;
  assign rel_angle = angle_raw - marker_offset;
  assign rel_prev  = angle_prev_r - marker_offset;
  assign wrap_fwd  = !delta[eeo_pkg::HALF_W-1] && (rel_angle < rel_prev);
  assign wrap_back = delta[eeo_pkg::HALF_W-1] && (rel_angle > rel_prev);

  // Emitted edges trail the target position, four edges per line.
  // A forward step needs a whole edge of travel, so a fractional remainder cannot make the phases dither.
  assign pos_diff = target_r - emitted_r;
  assign qstep_up = interp_mode ? interp_step_up :
                    (incr_mode && !pos_diff[ACC_W-1] && (pos_diff >= EDGE_UNIT));
  assign qstep_dn = interp_mode ? (interp_step_dn && !interp_step_up) :
                    (incr_mode && pos_diff[ACC_W-1]);

  eeo_quad_gen u_quad (
    .mclk    (mclk),
    .reset_n (reset_n),
    .step_up (qstep_up),
    .step_dn (qstep_dn),
    .quad_a  (qa),
    .quad_b  (qb)
  );

  // Incremental tracking: target is the signed angle travel times four lines.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      angle_prev_r <= '0;
      target_r     <= '0;
      emitted_r    <= '0;
    end else begin
      angle_prev_r <= angle_raw;
      target_r     <= target_r + ACC_W'({{(ACC_W-eeo_pkg::HALF_W){delta[eeo_pkg::HALF_W-1]}}, delta}
                      * ACC_W'({lines_eff, 2'b00}));
      if (qstep_up && !interp_mode) begin
        emitted_r <= emitted_r + ACC_W'(1 << eeo_pkg::HALF_W);
      end else if (qstep_dn && !interp_mode) begin
        emitted_r <= emitted_r - ACC_W'(1 << eeo_pkg::HALF_W);
      end
    end
  end

  // Marker: in incremental mode armed at the offset crossing, emitted while A and B are both high.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      marker_armed_r <= 1'b0;
      zero_marker_r  <= 1'b0;
    end else begin
      if (interp_mode) begin
        marker_armed_r <= 1'b0;
        zero_marker_r  <= sine_marker;
      end else if (incr_mode) begin
        if (wrap_fwd || wrap_back) begin
          marker_armed_r <= 1'b1;
        end else if (zero_marker_r && !(qa && qb)) begin
          marker_armed_r <= 1'b0;
        end
        zero_marker_r <= (marker_armed_r || zero_marker_r) && qa && qb;
      end else begin
        marker_armed_r <= 1'b0;
        zero_marker_r  <= 1'b0;
      end
    end
  end

  // Outputs held low when no incremental function is selected.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      quad_a <= 1'b0;
      quad_b <= 1'b0;
    end else begin
      quad_a <= (incr_mode || interp_mode) && qa;
      quad_b <= (incr_mode || interp_mode) && qb;
    end
  end
  assign zero_marker = zero_marker_r;

  // Single-turn angle scaled by the resolver pole count.
  assign angle_scaled = source_is_encoder ? angle_raw :
    (resolver_poles == eeo_pkg::POLES_4) ? {angle_raw[eeo_pkg::HALF_W-2:0], 1'b0} :
    (resolver_poles == eeo_pkg::POLES_6) ? eeo_pkg::HALF_W'((32'(angle_raw) * 3) & 32'hFFF) :
    angle_raw;

  // Upper half of the frame by format.
  assign top_half = multi_turn_select ? shaft_position[eeo_pkg::POS_W-1:eeo_pkg::HALF_W] :
                    (source_is_encoder && commutation_track && !homing_done) ? eeo_pkg::INVALID_TOP :
                    '0;
  assign frame_raw  = {top_half, multi_turn_select ? angle_raw : angle_scaled};
  assign frame_word = serial_code_select ? frame_raw : to_gray(frame_raw);

  // Serial clock synchroniser; the leading edge depends on the polarity setting.
  eeo_pin_sync u_sclk (
    .mclk    (mclk),
    .reset_n (reset_n),
    .pin     (serial_clk),
    .level   (sclk_lvl),
    .rise    (sclk_rise),
    .fall    (sclk_fall)
  );
  assign sclk_lead = serial_clock_invert ? sclk_rise : sclk_fall;

  // Frame shifter: first lead edge latches, each later one shifts MSB first.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r       <= eeo_pkg::FRAME_RST;
      busy_r        <= 1'b0;
      bits_r        <= '0;
      idle_r        <= '0;
      serial_data_r <= 1'b1;
    end else begin
      if (!serial_mode) begin
        busy_r        <= 1'b0;
        serial_data_r <= 1'b1;
      end else if (sclk_lead && !busy_r) begin
        shift_r       <= {frame_word[eeo_pkg::FRAME_W-2:0], 1'b0};
        serial_data_r <= frame_word[eeo_pkg::FRAME_W-1];
        busy_r        <= 1'b1;
        bits_r        <= eeo_pkg::CNT_W'(1);
        idle_r        <= '0;
      end else if (sclk_lead && busy_r) begin
        idle_r <= '0;
        if (bits_r < eeo_pkg::CNT_W'(eeo_pkg::FRAME_W)) begin
          serial_data_r <= shift_r[eeo_pkg::FRAME_W-1];
          shift_r       <= {shift_r[eeo_pkg::FRAME_W-2:0], 1'b0};
          bits_r        <= bits_r + 1'b1;
        end else begin
          serial_data_r <= 1'b0;
        end
      end else if (busy_r) begin
        if (idle_r == eeo_pkg::IDLE_W'(eeo_pkg::SER_IDLE_CYC)) begin
          busy_r        <= 1'b0;
          serial_data_r <= 1'b1;
        end else begin
          idle_r <= idle_r + 1'b1;
        end
      end
    end
  end
  assign serial_data = serial_data_r;

  // In incremental mode, no marker unless both phases are high.
  a_marker_ab_high: assert property (@(posedge mclk) disable iff (!reset_n)
    (zero_marker && incr_mode && $past(incr_mode)) |-> (quad_a || $past(qa)) && $past(qa) && $past(qb))
    else $error("Marker without A and B high");

  // Line limit for resolver source.
  a_line_limit: assert property (@(posedge mclk) disable iff (!reset_n)
    !source_is_encoder |-> lines_eff <= eeo_pkg::RES_LINES_MAX) else $error("Line count over limit");

  // Single-turn frame has zero or invalid top half.
  a_single_top: assert property (@(posedge mclk) disable iff (!reset_n)
    (!multi_turn_select && !(source_is_encoder && commutation_track && !homing_done))
      |-> frame_raw[eeo_pkg::FRAME_W-1:eeo_pkg::HALF_W] == '0) else $error("Single-turn top not zero");

  // Invalid flag for an unhomed commutation encoder.
  a_invalid_flag: assert property (@(posedge mclk) disable iff (!reset_n)
    (!multi_turn_select && source_is_encoder && commutation_track && !homing_done)
      |-> frame_raw[eeo_pkg::FRAME_W-1:eeo_pkg::HALF_W] == 12'hFFF) else $error("Invalid flag missing");

  // Multi-turn top carries turns.
  a_multi_turns: assert property (@(posedge mclk) disable iff (!reset_n)
    multi_turn_select |-> frame_raw == shaft_position) else $error("Multi-turn frame wrong");

  // Gray coding when binary is not chosen.
  a_gray_code: assert property (@(posedge mclk) disable iff (!reset_n)
    !serial_code_select |-> frame_word == (frame_raw ^ (frame_raw >> 1))) else $error("Gray coding wrong");

  // First lead edge of a word latches the frame MSB.
  a_frame_msb: assert property (@(posedge mclk) disable iff (!reset_n)
    (serial_mode && sclk_lead && !busy_r) |=> busy_r && serial_data == $past(frame_word[eeo_pkg::FRAME_W-1]))
    else $error("Frame MSB not latched");

  // Bit count never passes the frame length.
  a_frame_len: assert property (@(posedge mclk) disable iff (!reset_n)
    bits_r <= eeo_pkg::CNT_W'(eeo_pkg::FRAME_W)) else $error("Frame longer than 24 bits");

  // Interpolation passes the sine marker one cycle later.
  a_interp_pass: assert property (@(posedge mclk) disable iff (!reset_n)
    (interp_mode ##1 interp_mode) |-> zero_marker == $past(sine_marker)) else $error("Marker not passed");

  // Serial data idles high whenever the serial function was not selected.
  a_serial_idle: assert property (@(posedge mclk) disable iff (!reset_n)
    !$past(serial_mode) |-> serial_data) else $error("Serial data not idle");

  // Lead edges past the last frame bit only shift zeros.
  a_frame_refuse: assert property (@(posedge mclk) disable iff (!reset_n)
    (serial_mode && busy_r && sclk_lead && bits_r == eeo_pkg::CNT_W'(eeo_pkg::FRAME_W)) |=> !serial_data)
    else $error("Bit past frame end not zero");

  // Quadrature outputs rest low outside the incremental functions.
  a_quad_off: assert property (@(posedge mclk) disable iff (!reset_n)
    !$past(incr_mode || interp_mode) |-> !quad_a && !quad_b) else $error("Quadrature active while off");

  // No marker outside the incremental functions.
  a_marker_off: assert property (@(posedge mclk) disable iff (!reset_n)
    !$past(incr_mode || interp_mode) |-> !zero_marker) else $error("Marker active while off");

endmodule

// *** tb/eeo_ssi_reader.sv ***
// Model of the external reader that clocks the serial position frame out of the block.
`timescale 1ns/1ps
module eeo_ssi_reader (
  // Link pins.
  input  wire logic invert,
  input  wire logic serial_data,
  output logic      serial_clk
);
  // The reader parks its clock at the idle level between bursts.
  initial begin
    serial_clk = 1'b1;
  end

  // Gives a burst of lead edges and shifts one bit in just before each next lead edge, MSB first.
  task automatic read_frame(input int edges, input int half_ns, output logic [23:0] frame, output logic idle_bit);
    serial_clk = ~invert;
    #25000;
    idle_bit = serial_data;
    frame = 24'h000000;
    for (int i = 0; i < edges; i++) begin
      serial_clk = invert;
      #(half_ns);
      serial_clk = ~invert;
      #(half_ns);
      frame = {frame[22:0], serial_data};
    end
  endtask
endmodule

// *** tb/tb.sv ***
// Self-checking testbench of the encoder emulation output block.
`timescale 1ns/1ps
module tb;
  // Clock, reset and block inputs with their time-zero values.
  logic        mclk                      = 1'b0;
  logic        reset_n                   = 1'b0;
  logic [23:0] shaft_position            = 24'h000000;
  logic        source_is_encoder         = 1'b0;
  logic [1:0]  resolver_poles            = 2'h0;
  logic        commutation_track         = 1'b0;
  logic        homing_done               = 1'b0;
  logic [1:0]  emulation_function_select = 2'h1;
  logic [19:0] line_count                = 20'h01000;
  logic [2:0]  interp_exponent           = 3'h2;
  logic [11:0] marker_offset             = 12'h080;
  logic        multi_turn_select         = 1'b0;
  logic        serial_code_select        = 1'b0;
  logic        serial_clock_select       = 1'b0;
  logic        serial_clock_invert       = 1'b0;
  logic        interp_step_up            = 1'b0;
  logic        interp_step_dn            = 1'b0;
  logic        sine_marker               = 1'b0;
  logic        serial_clk;
  logic        serial_data;
  logic        quad_a;
  logic        quad_b;
  logic        zero_marker;
  // Bench counters and monitor state.
  int          fail_count  = 0;
  int          checks_done = 0;
  int          qpos, marks, skips, bad_marks;
  logic [1:0]  idx_q;
  logic        mark_q;
  wire  [1:0]  idx = {quad_b, quad_a ^ quad_b};

  // The clock toggles every 12.5 ns, half of its 25 ns period.
  always #12.5 mclk = ~mclk;

  // Block under test and the serial reader on its far side.
  eeo_encoder_emulation_output u_eeo_encoder_emulation_output (
    .mclk(mclk), .reset_n(reset_n), .shaft_position(shaft_position), .source_is_encoder(source_is_encoder),
    .resolver_poles(resolver_poles), .commutation_track(commutation_track), .homing_done(homing_done),
    .emulation_function_select(emulation_function_select), .line_count(line_count),
    .interp_exponent(interp_exponent), .marker_offset(marker_offset), .multi_turn_select(multi_turn_select),
    .serial_code_select(serial_code_select), .serial_clock_select(serial_clock_select),
    .serial_clock_invert(serial_clock_invert), .interp_step_up(interp_step_up),
    .interp_step_dn(interp_step_dn), .sine_marker(sine_marker), .serial_clk(serial_clk),
    .serial_data(serial_data), .quad_a(quad_a), .quad_b(quad_b), .zero_marker(zero_marker));
  eeo_ssi_reader u_eeo_ssi_reader (.invert(serial_clock_invert), .serial_data(serial_data), .serial_clk(serial_clk));

  // Decodes A/B into a signed count on the falling edge, where outputs are settled, and tallies markers.
  always @(negedge mclk) begin
    case (2'(idx - idx_q))
      2'h1: qpos++;
      2'h3: qpos--;
      2'h2: skips++;
      default: ;
    endcase
    if (zero_marker === 1'b1 && mark_q !== 1'b1) marks++;
    if (zero_marker === 1'b1 && emulation_function_select !== eeo_pkg::FUNC_INTERP && !(quad_a & quad_b)) bad_marks++;
    idx_q = idx;
    mark_q = zero_marker;
  end

  // Compares a value driven by the block.
  task automatic chk_val(input logic [23:0] got, input logic [23:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Compares a count gathered by the bench.
  task automatic chk_cnt(input int got, input int exp, input string what);
    checks_done++;
    if (got != exp) begin
      fail_count++;
      $display("Error at %0t: %s count %0d expected %0d", $time, what, got, exp);
    end
  endtask

  // Resets the block with a chosen function and line count, then clears the monitor.
  task automatic setup(input logic [1:0] mode, input logic [19:0] lines);
    @(posedge mclk);
    reset_n <= 1'b0;
    emulation_function_select <= mode;
    line_count <= lines;
    shaft_position <= 24'h000000;
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (4) @(posedge mclk);
    @(negedge mclk);
    qpos = 0;
    marks = 0;
    skips = 0;
    bad_marks = 0;
  endtask

  // Steps the shaft angle one count at a time, leaving room for the outputs to catch up.
  task automatic move(input int steps, input int dir);
    for (int i = 0; i < steps; i++) begin
      @(posedge mclk);
      shaft_position <= shaft_position + 24'(dir);
      repeat (7) @(posedge mclk);
    end
    repeat (16) @(posedge mclk);
    @(negedge mclk);
  endtask

  // Outputs right after reset.
  task automatic t_reset();
    setup(eeo_pkg::FUNC_INCR, 20'h01000);
    chk_val(24'(quad_a), 24'h000000, "reset a");
    chk_val(24'(quad_b), 24'h000000, "reset b");
    chk_val(24'(zero_marker), 24'h000000, "reset marker");
    chk_val(24'(serial_data), 24'h000001, "reset data");
  endtask

  // One line forward gives four ordered edges; one line back undoes them.
  task automatic t_dir();
    setup(eeo_pkg::FUNC_INCR, 20'h01000);
    move(1, 1);
    chk_cnt(qpos, 4, "forward edges");
    move(1, -1);
    chk_cnt(qpos, 0, "reverse edges");
    chk_cnt(skips, 0, "phase skips");
  endtask

  // Sweeps a sixteenth of a turn and counts edges and markers.
  task automatic t_sweep(input logic enc, input logic [19:0] lines, input logic [11:0] ofs, input int edges, input int mk);
    @(posedge mclk);
    source_is_encoder <= enc;
    marker_offset <= ofs;
    setup(eeo_pkg::FUNC_INCR, lines);
    move(256, 1);
    chk_cnt(qpos, edges, "sweep edges");
    chk_cnt(marks, mk, "sweep markers");
    chk_cnt(bad_marks, 0, "marker outside A=B=1");
    @(posedge mclk);
    source_is_encoder <= 1'b0;
  endtask

  // Serial function gives no quadrature; interpolation follows the step inputs and the sine marker.
  task automatic t_modes();
    setup(eeo_pkg::FUNC_SERIAL, 20'h01000);
    move(16, 1);
    chk_cnt(qpos, 0, "serial mode edges");
    setup(eeo_pkg::FUNC_OFF, 20'h01000);
    move(16, 1);
    chk_cnt(qpos + marks, 0, "off mode edges");
    setup(eeo_pkg::FUNC_INTERP, 20'h01000);
    for (int i = 0; i < 4; i++) begin
      @(posedge mclk);
      interp_step_up <= (i != 2);
      interp_step_dn <= (i == 2);
      sine_marker <= (i == 3);
      @(posedge mclk);
      interp_step_up <= 1'b0;
      interp_step_dn <= 1'b0;
      sine_marker <= 1'b0;
      repeat (6) @(posedge mclk);
    end
    @(negedge mclk);
    chk_cnt(qpos, 2, "interpolated edges");
    chk_cnt(marks, 1, "passed marker");
  endtask

  // Expected frame: {inv, slow, multi, bin, poles[1:0], enc, comm, homed} in c.
  function automatic logic [23:0] exp_frame(input logic [8:0] c, input logic [23:0] p);
    logic [11:0] ang;
    logic [11:0] top;
    logic [23:0] f;
    ang = p[11:0];
    if (!c[2] && c[4:3] == eeo_pkg::POLES_4) ang = 12'(p[11:0] * 2);
    if (!c[2] && c[4:3] == eeo_pkg::POLES_6) ang = 12'(p[11:0] * 3);
    top = c[6] ? p[23:12] : ((c[2] && c[1] && !c[0]) ? 12'hFFF : 12'h000);
    f = {top, ang};
    return c[5] ? f : (f ^ (f >> 1));
  endfunction

  // Serial frames over formats, codes, sources, rate select settings and polarities, plus an overlong burst, all read at one 100 ns half period.
  task automatic t_frames();
    logic [8:0]  cfg [7];
    logic [23:0] f;
    logic        idle;
    cfg = '{9'h000, 9'h140, 9'h0E0, 9'h028, 9'h130, 9'h026, 9'h027};
    setup(eeo_pkg::FUNC_SERIAL, 20'h01000);
    @(posedge mclk);
    shaft_position <= 24'hABC456;
    @(negedge mclk);
    u_eeo_ssi_reader.read_frame(25, 100, f, idle);
    chk_val(f, 24'({exp_frame(9'h000, 24'hABC456), 1'b0}), "overlong burst");
    for (int i = 0; i < 7; i++) begin
      @(posedge mclk);
      {serial_clock_invert, serial_clock_select, multi_turn_select, serial_code_select} <= cfg[i][8:5];
      {resolver_poles, source_is_encoder, commutation_track, homing_done} <= cfg[i][4:0];
      @(negedge mclk);
      u_eeo_ssi_reader.read_frame(24, 100, f, idle);
      chk_val(24'(idle), 24'h000001, "idle data");
      chk_val(f, exp_frame(cfg[i], 24'hABC456), "frame");
    end
    setup(eeo_pkg::FUNC_INCR, 20'h01000);
    u_eeo_ssi_reader.read_frame(24, 100, f, idle);
    chk_val(f, 24'hFFFFFF, "no frame outside serial");
  endtask

  // Prints the verdict and ends the run.
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence.
  initial begin
    t_reset();
    t_dir();
    t_sweep(1'b0, 20'h01000, 12'h080, 1024, 1);
    t_sweep(1'b0, 20'h00400, 12'h200, 256, 0);
    t_sweep(1'b0, 20'h02000, 12'h0C0, 1024, 1);
    t_sweep(1'b1, 20'h00080, 12'h040, 64, 1);
    t_modes();
    t_frames();
    summarize();
  end

  // Cuts a hang short well past the expected run time.
  initial begin
    #2000000;
    fail_count++;
    $display("Error at %0t: run did not finish", $time);
    summarize();
  end
endmodule
